//--- rtl/scu_system_control.sv
// Upper fields of the system control register behind an APB slave
`timescale 1ns/10ps
`include "scu_cfg.svh"
module scu_system_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SCU_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic isa_reset_strap_input,
  input wire logic byte_order_reset_strap,
  input wire logic secure_write_lock_input,
  input wire logic nonsecure_state,
  input wire logic long_descriptor_select,
  input wire logic exception_entry,
  output scu_pkg::scu_entry_t entry_out,
  output scu_pkg::scu_walk_t walk_cfg,
  output logic undef_exception
);
  import scu_pkg::*;

  // Read image of one bank, reserved bits at their fixed values
  function automatic logic [31:0] fn_read(input scu_bank_t b,
                                          input logic lds);
    logic [31:0] v;
    v = `SCU_RAO_MASK;
    v[`SCU_TE_BIT] = b.te;
    v[`SCU_AFE_BIT] = lds ? `SCU_LDS_READ : b.afe;
    v[`SCU_TRE_BIT] = lds ? `SCU_LDS_READ : b.attr_remap_enable;
    v[`SCU_EE_BIT] = b.ee;
    return v;
  endfunction

  // Bank picked by the security state of a request
  function automatic logic fn_bank(input logic ns);
    return ns ? `SCU_BANK_NS : `SCU_BANK_SEC;
  endfunction

  // Two-flop synchronisers for the two strap inputs and the lock input
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic lock1_r;
  logic lock2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
      lock1_r <= 1'b0;
      lock2_r <= 1'b0;
    end else begin
      s1_r <= {isa_reset_strap_input, byte_order_reset_strap};
      s2_r <= s1_r;
      lock1_r <= secure_write_lock_input;
      lock2_r <= lock1_r;
    end
  end

  scu_state_t state_r, state_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  scu_bank_t bank_r [2];
  scu_bank_t bank_nxt [2];
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic wr_ok_r, wr_ok_nxt;
  logic wr_ns_r, wr_ns_nxt;
  logic undef_req_r, undef_req_nxt;
  logic undef_r, undef_nxt;
  scu_entry_t entry_r, entry_nxt;
  scu_walk_t walk_r, walk_nxt;
  logic setup;
  logic hit;
  logic priv;
  logic sec_locked;
  scu_bank_t cur;
  scu_bank_t src;

  assign setup = psel && !penable;
  assign hit = (paddr == `SCU_SCTL_OFF);
  assign priv = pprot[`SCU_PROT_PRIV];
  assign sec_locked = !pprot[`SCU_PROT_NS] && lock2_r;
  assign cur = bank_r[fn_bank(nonsecure_state)];

  // Next state of the bus slave, the banks and the side outputs
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    bank_nxt = bank_r;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    wr_ok_nxt = wr_ok_r;
    wr_ns_nxt = wr_ns_r;
    undef_req_nxt = undef_req_r;
    undef_nxt = 1'b0;
    entry_nxt = '0;
    src = cur;
    unique case (state_r)
      SCU_ST_INIT: begin
        cnt_nxt = cnt_r + 2'h1;
        if (cnt_r == `SCU_STRAP_WAIT) begin
          for (int i = 0; i < 2; i++) begin
            bank_nxt[i].te = s2_r[1];
            bank_nxt[i].ee = s2_r[0];
            bank_nxt[i].afe = `SCU_AFE_RST;
            bank_nxt[i].attr_remap_enable = `SCU_TRE_RST;
          end
          src = bank_nxt[fn_bank(nonsecure_state)];
          entry_nxt.taken = 1'b1;
          state_nxt = SCU_ST_IDLE;
        end
      end
      SCU_ST_IDLE: begin
        if (setup) begin
          // privileged access only, one copy per state
          wr_ok_nxt = pwrite && hit && priv && !sec_locked;
          wr_ns_nxt = pprot[`SCU_PROT_NS];
          undef_req_nxt = pwrite && hit && priv && sec_locked;
          pslverr_nxt = !hit || !priv || (pwrite && sec_locked);
          prdata_nxt = (!pwrite && hit && priv)
            ? fn_read(bank_r[fn_bank(pprot[`SCU_PROT_NS])],
                      long_descriptor_select)
            : `SCU_ZERO_WORD;
          pready_nxt = 1'b1;
          state_nxt = SCU_ST_ACC;
        end
      end
      SCU_ST_ACC: begin
        if (psel && penable) begin
          // only implemented bits take write data
          if (wr_ok_r) begin
            bank_nxt[fn_bank(wr_ns_r)].te = pwdata[`SCU_TE_BIT];
            bank_nxt[fn_bank(wr_ns_r)].afe = pwdata[`SCU_AFE_BIT];
            bank_nxt[fn_bank(wr_ns_r)].attr_remap_enable = pwdata[`SCU_TRE_BIT];
            bank_nxt[fn_bank(wr_ns_r)].ee = pwdata[`SCU_EE_BIT];
          end
          undef_nxt = undef_req_r;
          state_nxt = SCU_ST_IDLE;
        end else begin
          pready_nxt = pready_r;
          pslverr_nxt = pslverr_r;
        end
      end
      default: state_nxt = SCU_ST_INIT;
    endcase
    if (state_r != SCU_ST_INIT && exception_entry) begin
      entry_nxt.taken = 1'b1;
    end
    entry_nxt.isa_compact = entry_nxt.taken && src.te;
    entry_nxt.byte_order = entry_nxt.taken && src.ee;
    // walk byte order; access flag model; remap
    walk_nxt.big_endian = cur.ee;
    walk_nxt.access_flag_en = cur.afe;
    walk_nxt.attr_remap_en = cur.attr_remap_enable;
  end

  // Register all state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SCU_ST_INIT;
      cnt_r <= 2'h0;
      bank_r[0] <= '0;
      bank_r[1] <= '0;
      prdata_r <= `SCU_ZERO_WORD;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      wr_ok_r <= 1'b0;
      wr_ns_r <= 1'b0;
      undef_req_r <= 1'b0;
      undef_r <= 1'b0;
      entry_r <= '0;
      walk_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      bank_r <= bank_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      wr_ok_r <= wr_ok_nxt;
      wr_ns_r <= wr_ns_nxt;
      undef_req_r <= undef_req_nxt;
      undef_r <= undef_nxt;
      entry_r <= entry_nxt;
      walk_r <= walk_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign entry_out = entry_r;
  assign walk_cfg = walk_r;
  assign undef_exception = undef_r;

  // Checks on strap loading, bus answers and entry outputs
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic acc_edge;
  assign acc_edge = psel && penable && pready_r;

  a_strap_isa_load: assert property (
    state_r == SCU_ST_INIT && cnt_r == `SCU_STRAP_WAIT
    |=> bank_r[0].te == $past(s2_r[1]) && bank_r[1].te == $past(s2_r[1]))
    else $error("isa bit not loaded from strap");
  a_strap_end_load: assert property (
    state_r == SCU_ST_INIT && cnt_r == `SCU_STRAP_WAIT
    |=> bank_r[0].ee == $past(s2_r[0]) && bank_r[1].ee == $past(s2_r[0]))
    else $error("byte order bit not loaded from strap");
  a_afe_reset: assert property (
    state_r == SCU_ST_INIT |=> !bank_r[0].afe && !bank_r[1].afe)
    else $error("access flag enable not zero after reset");
  a_entry_isa: assert property (
    state_r == SCU_ST_IDLE && exception_entry
    |=> entry_out.taken && entry_out.isa_compact == $past(cur.te))
    else $error("entry instruction state wrong");
  a_entry_endian: assert property (
    state_r == SCU_ST_IDLE && exception_entry
    |=> entry_out.byte_order == $past(cur.ee))
    else $error("entry endian flag wrong");
  a_walk_cfg: assert property (
    state_r != SCU_ST_INIT |=> walk_cfg.access_flag_en == $past(cur.afe)
    && walk_cfg.attr_remap_en == $past(cur.attr_remap_enable)
    && walk_cfg.big_endian == $past(cur.ee))
    else $error("walker settings do not follow bank");
  a_lds_read_one: assert property (
    state_r == SCU_ST_IDLE && setup && !pwrite && hit && priv
    && long_descriptor_select
    |=> prdata[`SCU_AFE_BIT] && prdata[`SCU_TRE_BIT])
    else $error("long descriptor read not one");
  a_fixed_bits: assert property (
    pready && !pslverr && prdata != `SCU_ZERO_WORD
    |-> (prdata & `SCU_RAO_MASK) == `SCU_RAO_MASK
    && (prdata & `SCU_RAZ_MASK) == `SCU_ZERO_WORD)
    else $error("reserved bits read wrong");
  a_unpriv_err: assert property (
    state_r == SCU_ST_IDLE && setup && !priv
    |=> pready && pslverr && prdata == `SCU_ZERO_WORD)
    else $error("unprivileged access not refused");
  a_lock_blocks: assert property (
    acc_edge && undef_req_r
    |=> undef_exception && $stable(bank_r[0]) ##1 !undef_exception)
    else $error("locked secure write not refused");
  a_ready_one: assert property (
    state_r == SCU_ST_IDLE && setup |=> pready ##1 !pready)
    else $error("answer not one cycle");
  // Remap reset value, refused transfers, isolation of the two copies and quiet entry flags
  a_tre_reset: assert property (
    state_r == SCU_ST_INIT |=> !bank_r[0].attr_remap_enable && !bank_r[1].attr_remap_enable)
    else $error("remap enable not zero after reset");
  a_undef_cause: assert property (
    undef_exception |-> $past(acc_edge && undef_req_r))
    else $error("undefined pulse without locked write");
  a_refused_keep: assert property (
    acc_edge && pslverr_r
    |=> $stable(bank_r[0]) && $stable(bank_r[1]))
    else $error("refused transfer changed a copy");
  a_ns_write_only: assert property (
    acc_edge && wr_ok_r && wr_ns_r |=> $stable(bank_r[0]))
    else $error("non-secure write reached secure copy");
  a_sec_write_only: assert property (
    acc_edge && wr_ok_r && !wr_ns_r |=> $stable(bank_r[1]))
    else $error("secure write reached non-secure copy");
  a_entry_quiet: assert property (
    !entry_out.taken |-> !entry_out.isa_compact && !entry_out.byte_order)
    else $error("entry flags set without entry");

  // Main scenarios reached
  c_write_ok: cover property (acc_edge && wr_ok_r);
  c_ns_write: cover property (acc_edge && wr_ok_r && wr_ns_r);
  c_locked_write: cover property (acc_edge && undef_req_r);
  c_entry: cover property (entry_out.taken && entry_out.isa_compact);
  c_lds_read: cover property (setup && long_descriptor_select && !pwrite);
endmodule

//--- shared/scu_cfg.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef SCU_CFG_SVH
`define SCU_CFG_SVH
`define SCU_SCTL_OFF 12'h000
`define SCU_ADDR_W 12
`define SCU_TE_BIT 30
`define SCU_AFE_BIT 29
`define SCU_TRE_BIT 28
`define SCU_EE_BIT 25
`define SCU_RAO_MASK 32'h00C0_0000
`define SCU_RAZ_MASK 32'h0920_0000
`define SCU_ZERO_WORD 32'h0000_0000
`define SCU_AFE_RST 1'b0
`define SCU_TRE_RST 1'b0
`define SCU_LDS_READ 1'b1
`define SCU_STRAP_WAIT 2'h2
`define SCU_BANK_SEC 1'b0
`define SCU_BANK_NS 1'b1
`define SCU_PROT_PRIV 0
`define SCU_PROT_NS 1
`endif

//--- shared/scu_pkg.sv
// Types shared by the system control register block
package scu_pkg;
  // One security-state copy of the implemented control bits
  typedef struct packed {
    logic te;
    logic afe;
    logic attr_remap_enable;
    logic ee;
  } scu_bank_t;
  // Settings handed to the translation walker
  typedef struct packed {
    logic big_endian;
    logic access_flag_en;
    logic attr_remap_en;
  } scu_walk_t;
  // Exception entry outputs
  typedef struct packed {
    logic taken;
    logic isa_compact;
    logic byte_order;
  } scu_entry_t;
  // Bus slave states, one-hot
  typedef enum logic [2:0] {
    SCU_ST_INIT = 3'b001,
    SCU_ST_IDLE = 3'b010,
    SCU_ST_ACC = 3'b100
  } scu_state_t;
endpackage

//--- test/test_system_control_upper_fields.sv
// Self-checking bench for the upper system control fields
`timescale 1ns/10ps
`include "scu_cfg.svh"
module test_system_control_upper_fields;
  import scu_pkg::*;
  typedef struct packed {
    logic w;
    logic [2:0] prot;
    logic [11:0] addr;
    logic [31:0] wd;
    logic [31:0] rd;
    logic err;
  } scu_row_t;
  logic pclk, presetn, psel, penable, pwrite;
  logic [`SCU_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] pprot;
  logic pready, pslverr, err, te_strap, ee_strap, lock, ns, lds, exc;
  logic undef_exception;
  scu_entry_t entry_out;
  scu_walk_t walk_cfg;
  int err_total = 0;
  int cmp_count = 0;
  int i;
  scu_row_t rows [0:11];
  scu_system_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .isa_reset_strap_input(te_strap), .byte_order_reset_strap(ee_strap),
    .secure_write_lock_input(lock), .nonsecure_state(ns),
    .long_descriptor_select(lds), .exception_entry(exc),
    .entry_out(entry_out), .walk_cfg(walk_cfg),
    .undef_exception(undef_exception));
  // Clock at 100 MHz
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, then one idle edge
  task automatic apb(input logic w, input logic [2:0] pr,
                     input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pprot <= pr;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Reset with given straps, then wait for the reset entry pulse
  task automatic do_reset(input logic te, input logic ee);
    int n;
    presetn <= 1'b0;
    te_strap <= te;
    ee_strap <= ee;
    repeat (12) @(posedge pclk);
    chk({29'h0, entry_out}, 32'h0);
    presetn <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      #1 n++;
    end while (entry_out.taken !== 1'b1 && n < 6);
    chk({29'h0, entry_out}, {29'h0, 1'b1, te, ee});
    repeat (2) @(posedge pclk);
  endtask
  // Pulse an exception entry for the selected copy
  task automatic entry(input logic s, input logic [2:0] e,
                       input logic [2:0] wc);
    ns <= s;
    exc <= 1'b1;
    @(posedge pclk);
    exc <= 1'b0;
    @(posedge pclk);
    // Both outputs stood since the edge that took the pulse
    chk({29'h0, entry_out}, {29'h0, e});
    chk({29'h0, walk_cfg}, {29'h0, wc});
  endtask
  task automatic final_report();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #40000;
    err_total++;
    final_report();
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; pprot = 3'h1; te_strap = 1'b1;
    ee_strap = 1'b0; lock = 1'b0; ns = 1'b0; lds = 1'b0; exc = 1'b0;
    rows = '{'{1'b0, 3'h1, 12'h000, 32'h0, 32'h40C0_0000, 1'b0},
      '{1'b1, 3'h1, 12'h000, 32'hFFFF_FFFF, 32'h0, 1'b0},
      '{1'b0, 3'h1, 12'h000, 32'h0, 32'h72C0_0000, 1'b0},
      '{1'b0, 3'h3, 12'h000, 32'h0, 32'h40C0_0000, 1'b0},
      '{1'b1, 3'h3, 12'h000, 32'h0, 32'h0, 1'b0},
      '{1'b0, 3'h3, 12'h000, 32'h0, 32'h00C0_0000, 1'b0},
      '{1'b0, 3'h0, 12'h000, 32'h0, 32'h0, 1'b1},
      '{1'b1, 3'h2, 12'h000, 32'hFFFF_FFFF, 32'h0, 1'b1},
      '{1'b0, 3'h3, 12'h000, 32'h0, 32'h00C0_0000, 1'b0},
      '{1'b0, 3'h1, 12'h004, 32'h0, 32'h0, 1'b1},
      '{1'b1, 3'h1, 12'h004, 32'h0, 32'h0, 1'b1},
      '{1'b0, 3'h1, 12'h000, 32'h0, 32'h72C0_0000, 1'b0}};
    // first reset, straps 1 and 0
    do_reset(1'b1, 1'b0);
    for (i = 0; i < 12; i++) begin
      apb(rows[i].w, rows[i].prot, rows[i].addr, rows[i].wd);
      chk({31'h0, err}, {31'h0, rows[i].err});
      if (!rows[i].w) chk(rd, rows[i].rd);
    end
    // locked secure write is refused and raises undefined
    lock <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, 3'h1, 12'h000, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Pulse from the refused write stands until this edge
    chk({31'h0, undef_exception}, 32'h1);
    apb(1'b0, 3'h1, 12'h000, 32'h0);
    chk(rd, 32'h72C0_0000);
    apb(1'b1, 3'h3, 12'h000, 32'h4000_0000);
    chk({31'h0, err}, 32'h0);
    lock <= 1'b0;
    // long-descriptor select reads bits 29 and 28 as one
    lds <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 3'h3, 12'h000, 32'h0);
    chk(rd, 32'h70C0_0000);
    lds <= 1'b0;
    @(posedge pclk);
    // entry and walker outputs per copy
    entry(1'b0, 3'b111, 3'b111);
    entry(1'b1, 3'b110, 3'b000);
    // second reset with the other straps
    ns <= 1'b0;
    do_reset(1'b0, 1'b1);
    chk({29'h0, walk_cfg}, 32'h4);
    apb(1'b0, 3'h3, 12'h000, 32'h0);
    chk(rd, 32'h02C0_0000);
    final_report();
  end
endmodule
